//--- hdl/pem_regs.sv
// Behaviour
// - Extended status 1000X full duplex reads 1
// - Extended status 1000X half duplex reads 0
// - Both twisted-pair gigabit bits read 0
// - Autoneg completion sets status while enabled
// - Status holds until host writes 0
// - Enable low forces status to 0
// - Interrupt output follows status bit
// - Enable bit read/write, resets to 1
// - Position 0: loopback inside own logic
// - Position 1: loopback inside transceiver
// - Position only selects; control bit enables
// - Decode addresses 0-8 and 15-20
// - Control bit 14 enables loopback
`timescale 1ns/1ps
`include "pem_cfg.svh"

module pem_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pem_pkg::pem_req_s req_i,
  output pem_pkg::pem_word_t rdata_o,
  input wire logic an_complete_i,
  input wire logic loopback_position_default_i,
  input wire pem_pkg::pem_word_t core_rdata_i [`PEM_CORE_WORDS],
  output pem_pkg::pem_req_s core_req_o,
  input wire pem_pkg::pem_cg_t tx_cg_i,
  input wire pem_pkg::pem_cg_t serdes_rx_cg_i,
  output pem_pkg::pem_cg_t serdes_tx_cg_o,
  output pem_pkg::pem_cg_t pcs_rx_cg_o,
  output logic serdes_loopback_o,
  output logic loopback_enable_o,
  output logic autoneg_done_irq_out_o,
  output logic evt_irq_o
);
  import pem_pkg::*;

  function automatic pem_region_e pem_region(input pem_addr_t a);
    pem_region_e r;
    r = PEM_REG_NONE;
    if (a <= `PEM_ADDR_CORE_LAST) begin
      r = PEM_REG_CORE;
    end else begin
      unique case (a)
        `PEM_ADDR_EXT_STATUS: r = PEM_REG_EXT;
        `PEM_ADDR_AN_IRQ: r = PEM_REG_AN_IRQ;
        `PEM_ADDR_LB_POS: r = PEM_REG_LB_POS;
        `PEM_ADDR_EVT_STATUS: r = PEM_REG_EVT_ST;
        `PEM_ADDR_EVT_CLEAR: r = PEM_REG_EVT_CLR;
        `PEM_ADDR_EVT_ENABLE: r = PEM_REG_EVT_EN;
        default: r = PEM_REG_NONE;
      endcase
    end
    return r;
  endfunction : pem_region

  pem_region_e region;
  logic wr_an_irq;
  logic wr_lb_pos;
  logic wr_ctrl;
  logic lb_en_reg;
  logic lb_pos_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;
  logic strap_taken_reg;
  logic an_en_reg;
  logic an_en_next;
  logic an_stat_reg;
  logic an_stat_next;
  pem_word_t rdata_reg;
  pem_word_t rdata_next;
  pem_req_s core_req_reg;
  pem_evt_t evt_in;
  pem_evt_t evt_status;
  pem_evt_t evt_enable;
  logic evt_irq;
  pem_word_t ctrl_word;

  assign region = pem_region(req_i.addr);
  assign wr_ctrl = req_i.wr && (req_i.addr == `PEM_ADDR_CTRL);
  assign wr_an_irq = req_i.wr && (region == PEM_REG_AN_IRQ);
  assign wr_lb_pos = req_i.wr && (region == PEM_REG_LB_POS);

  // Loopback enable lives here; the rest of register 0 belongs to the core
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lb_en_reg <= `PEM_CTRL_LOOPBACK_RST;
    end else if (wr_ctrl) begin
      lb_en_reg <= req_i.wdata[`PEM_CTRL_LOOPBACK_BIT];
    end
  end

  // Strap pin is asynchronous; not reset so it is valid at release
  always_ff @(posedge mclk_i) begin
    strap_meta_reg <= loopback_position_default_i;
    strap_sync_reg <= strap_meta_reg;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      strap_taken_reg <= 1'b0;
    end else begin
      strap_taken_reg <= 1'b1;
    end
  end

  // Strap is loaded at the first edge after release; a write there wins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lb_pos_reg <= `PEM_LB_POS_RST;
    end else if (wr_lb_pos) begin
      lb_pos_reg <= req_i.wdata[`PEM_LB_POS_BIT];
    end else if (!strap_taken_reg) begin
      lb_pos_reg <= strap_sync_reg;
    end
  end

  assign an_en_next = wr_an_irq ? req_i.wdata[`PEM_AN_IRQ_ENABLE_BIT] : an_en_reg;

  always_comb begin
    an_stat_next = an_stat_reg;
    if (!an_en_next) begin
      an_stat_next = 1'b0;
    end else if (an_complete_i) begin
      an_stat_next = 1'b1;
    end else if (wr_an_irq && !req_i.wdata[`PEM_AN_IRQ_STATUS_BIT]) begin
      an_stat_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      an_en_reg <= `PEM_AN_IRQ_ENABLE_RST;
    end else begin
      an_en_reg <= an_en_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      an_stat_reg <= `PEM_AN_IRQ_STATUS_RST;
    end else begin
      an_stat_reg <= an_stat_next;
    end
  end

  assign autoneg_done_irq_out_o = an_stat_reg;

  always_comb begin
    ctrl_word = core_rdata_i[0];
    ctrl_word[`PEM_CTRL_LOOPBACK_BIT] = lb_en_reg;
  end

  always_comb begin
    rdata_next = `PEM_WORD_ZERO;
    if (req_i.rd) begin
      unique case (region)
        PEM_REG_CORE: begin
          if (req_i.addr == `PEM_ADDR_CTRL) begin
            rdata_next = ctrl_word;
          end else begin
            rdata_next = core_rdata_i[req_i.addr[3:0]];
          end
        end
        PEM_REG_EXT: rdata_next = `PEM_EXT_STATUS_VALUE;
        PEM_REG_AN_IRQ: begin
          rdata_next[`PEM_AN_IRQ_STATUS_BIT] = an_stat_reg;
          rdata_next[`PEM_AN_IRQ_ENABLE_BIT] = an_en_reg;
        end
        PEM_REG_LB_POS: rdata_next[`PEM_LB_POS_BIT] = lb_pos_reg;
        PEM_REG_EVT_ST: rdata_next[`PEM_EVT_COUNT-1:0] = evt_status;
        PEM_REG_EVT_EN: rdata_next[`PEM_EVT_COUNT-1:0] = evt_enable;
        PEM_REG_EVT_CLR: rdata_next = `PEM_WORD_ZERO;
        PEM_REG_NONE: rdata_next = `PEM_WORD_ZERO;
      endcase
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_reg <= `PEM_WORD_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // Core reads are forwarded too, so read side effects in the core still fire
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      core_req_reg <= '0;
    end else begin
      core_req_reg.wr <= req_i.wr && (region == PEM_REG_CORE);
      core_req_reg.rd <= req_i.rd && (region == PEM_REG_CORE);
      core_req_reg.addr <= req_i.addr;
      core_req_reg.wdata <= req_i.wdata;
    end
  end

  assign core_req_o = core_req_reg;

  assign evt_in[`PEM_EVT_AN_DONE_BIT] = an_complete_i;
  assign evt_in[`PEM_EVT_UNMAPPED_BIT] = (req_i.rd || req_i.wr) && (region == PEM_REG_NONE);

  pem_evt_irq u_evt_irq (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .event_i(evt_in),
    .clear_wr_i(req_i.wr && (region == PEM_REG_EVT_CLR)),
    .enable_wr_i(req_i.wr && (region == PEM_REG_EVT_EN)),
    .wdata_i(req_i.wdata[`PEM_EVT_COUNT-1:0]),
    .status_o(evt_status),
    .enable_o(evt_enable),
    .irq_o(evt_irq)
  );

  assign evt_irq_o = evt_irq;
  assign loopback_enable_o = lb_en_reg;

  pem_loopback_sel u_lb (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .lb_internal_i(lb_en_reg && !lb_pos_reg),
    .lb_transceiver_i(lb_en_reg && lb_pos_reg),
    .tx_cg_i(tx_cg_i),
    .serdes_rx_cg_i(serdes_rx_cg_i),
    .serdes_tx_cg_o(serdes_tx_cg_o),
    .pcs_rx_cg_o(pcs_rx_cg_o),
    .serdes_loopback_o(serdes_loopback_o)
  );

  AST_EXT_FD_ONE: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (req_i.rd && req_i.addr == `PEM_ADDR_EXT_STATUS) |=> rdata_o[`PEM_EXT_1000X_FD_BIT])
    else $error("extended status full duplex bit not 1");

  AST_EXT_HD_ZERO: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (req_i.rd && req_i.addr == `PEM_ADDR_EXT_STATUS) |=> !rdata_o[`PEM_EXT_1000X_HD_BIT])
    else $error("extended status half duplex bit not 0");

  AST_EXT_T_ZERO: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (req_i.rd && req_i.addr == `PEM_ADDR_EXT_STATUS)
      |=> rdata_o[`PEM_EXT_1000T_FD_BIT:`PEM_EXT_1000T_HD_BIT] == 2'h0)
    else $error("twisted-pair capability bits not 0");

  AST_AN_SET: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (an_complete_i && an_en_reg && !wr_an_irq) |=> autoneg_done_irq_out_o)
    else $error("autoneg completion did not raise status");

  AST_AN_HOLD: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (an_stat_reg && !wr_an_irq) |=> an_stat_reg)
    else $error("status cleared without a host write");

  AST_AN_DISABLED: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (wr_an_irq && !req_i.wdata[`PEM_AN_IRQ_ENABLE_BIT]) |=> !an_stat_reg [*1] ##0 !an_en_reg)
    else $error("status not forced low while disabled");

  AST_IRQ_CAUSE: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    $rose(autoneg_done_irq_out_o) |-> $past(an_complete_i) && $past(an_en_next))
    else $error("interrupt output rose without completion");

  AST_EN_READBACK: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (req_i.rd && req_i.addr == `PEM_ADDR_AN_IRQ)
      |=> rdata_o == {14'h0, $past(an_stat_reg), $past(an_en_reg)})
    else $error("interrupt control readback wrong");

  AST_LB_INTERNAL: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (lb_en_reg && !lb_pos_reg) |=> pcs_rx_cg_o == $past(tx_cg_i) && !serdes_loopback_o)
    else $error("internal loopback path not selected");

  AST_LB_SERDES: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (lb_en_reg && lb_pos_reg) |=> serdes_loopback_o && pcs_rx_cg_o == $past(serdes_rx_cg_i))
    else $error("transceiver loopback not requested");

  // Release edge skipped: code group flops still take their reset value there
  AST_LB_OFF: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!lb_en_reg && !$past(rst_i))
      |=> !serdes_loopback_o && pcs_rx_cg_o == $past(serdes_rx_cg_i))
    else $error("loopback active while disabled");

  AST_UNMAPPED_ZERO: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (req_i.rd && pem_region(req_i.addr) == PEM_REG_NONE) |=> rdata_o == `PEM_WORD_ZERO)
    else $error("unmapped read returned data");

  AST_CTRL_LB: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    wr_ctrl |=> loopback_enable_o == $past(req_i.wdata[`PEM_CTRL_LOOPBACK_BIT]))
    else $error("control loopback bit not taken");

  AST_LB_RESERVED: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (req_i.rd && req_i.addr == `PEM_ADDR_LB_POS) |=> rdata_o[15:1] == 15'h0)
    else $error("reserved loopback position bits not 0");
endmodule : pem_regs

//--- hdl/pem_cfg.svh
`ifndef PEM_CFG_SVH
`define PEM_CFG_SVH

`define PEM_AW 5
`define PEM_DW 16
`define PEM_CG_W 10
`define PEM_CORE_WORDS 9
`define PEM_EVT_COUNT 2

`define PEM_ADDR_CTRL 5'h00
`define PEM_ADDR_CORE_LAST 5'h08
`define PEM_ADDR_EXT_STATUS 5'h0f
`define PEM_ADDR_AN_IRQ 5'h10
`define PEM_ADDR_LB_POS 5'h11
`define PEM_ADDR_EVT_STATUS 5'h12
`define PEM_ADDR_EVT_CLEAR 5'h13
`define PEM_ADDR_EVT_ENABLE 5'h14

`define PEM_CTRL_LOOPBACK_BIT 14
`define PEM_EXT_1000X_FD_BIT 15
`define PEM_EXT_1000X_HD_BIT 14
`define PEM_EXT_1000T_FD_BIT 13
`define PEM_EXT_1000T_HD_BIT 12
`define PEM_AN_IRQ_STATUS_BIT 1
`define PEM_AN_IRQ_ENABLE_BIT 0
`define PEM_LB_POS_BIT 0
`define PEM_EVT_AN_DONE_BIT 0
`define PEM_EVT_UNMAPPED_BIT 1

`define PEM_EXT_STATUS_VALUE 16'h8000
`define PEM_CTRL_LOOPBACK_RST 1'b0
`define PEM_AN_IRQ_ENABLE_RST 1'b1
`define PEM_AN_IRQ_STATUS_RST 1'b0
`define PEM_LB_POS_RST 1'b0
`define PEM_EVT_ENABLE_RST 2'h0
`define PEM_EVT_STATUS_RST 2'h0
`define PEM_WORD_ZERO 16'h0000
`define PEM_CG_ZERO 10'h000

`endif

//--- hdl/pem_pkg.sv
`include "pem_cfg.svh"

package pem_pkg;
  typedef logic [`PEM_AW-1:0] pem_addr_t;
  typedef logic [`PEM_DW-1:0] pem_word_t;
  typedef logic [`PEM_CG_W-1:0] pem_cg_t;
  typedef logic [`PEM_EVT_COUNT-1:0] pem_evt_t;

  typedef struct packed {
    logic wr;
    logic rd;
    pem_addr_t addr;
    pem_word_t wdata;
  } pem_req_s;

  typedef enum logic [2:0] {
    PEM_REG_CORE = 3'b000,
    PEM_REG_EXT = 3'b001,
    PEM_REG_AN_IRQ = 3'b010,
    PEM_REG_LB_POS = 3'b011,
    PEM_REG_EVT_ST = 3'b100,
    PEM_REG_EVT_CLR = 3'b101,
    PEM_REG_EVT_EN = 3'b110,
    PEM_REG_NONE = 3'b111
  } pem_region_e;
endpackage : pem_pkg

//--- hdl/pem_evt_irq.sv
`timescale 1ns/1ps
`include "pem_cfg.svh"

module pem_evt_irq (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pem_pkg::pem_evt_t event_i,
  input wire logic clear_wr_i,
  input wire logic enable_wr_i,
  input wire pem_pkg::pem_evt_t wdata_i,
  output pem_pkg::pem_evt_t status_o,
  output pem_pkg::pem_evt_t enable_o,
  output logic irq_o
);
  import pem_pkg::*;

  pem_evt_t status_reg;
  pem_evt_t status_next;
  pem_evt_t enable_reg;
  pem_evt_t enable_next;
  logic irq_reg;

  assign enable_next = enable_wr_i ? wdata_i : enable_reg;

  // Set beats a clear landing in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `PEM_EVT_COUNT; gi++) begin : g_bit
      assign status_next[gi] = event_i[gi] | (status_reg[gi] & ~(clear_wr_i & wdata_i[gi]));
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status_reg <= `PEM_EVT_STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      enable_reg <= `PEM_EVT_ENABLE_RST;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // Built from next values so the line tracks the status flop exactly
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & enable_next);
    end
  end

  assign status_o = status_reg;
  assign enable_o = enable_reg;
  assign irq_o = irq_reg;
endmodule : pem_evt_irq

//--- hdl/pem_loopback_sel.sv
`timescale 1ns/1ps
`include "pem_cfg.svh"

module pem_loopback_sel (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic lb_internal_i,
  input wire logic lb_transceiver_i,
  input wire pem_pkg::pem_cg_t tx_cg_i,
  input wire pem_pkg::pem_cg_t serdes_rx_cg_i,
  output pem_pkg::pem_cg_t serdes_tx_cg_o,
  output pem_pkg::pem_cg_t pcs_rx_cg_o,
  output logic serdes_loopback_o
);
  import pem_pkg::*;

  pem_cg_t serdes_tx_reg;
  pem_cg_t pcs_rx_reg;
  logic serdes_lb_reg;

  // Transmit keeps running during internal loopback so the far end stays synced
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      serdes_tx_reg <= `PEM_CG_ZERO;
    end else begin
      serdes_tx_reg <= tx_cg_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pcs_rx_reg <= `PEM_CG_ZERO;
    end else if (lb_internal_i) begin
      pcs_rx_reg <= tx_cg_i;
    end else begin
      pcs_rx_reg <= serdes_rx_cg_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      serdes_lb_reg <= 1'b0;
    end else begin
      serdes_lb_reg <= lb_transceiver_i;
    end
  end

  assign serdes_tx_cg_o = serdes_tx_reg;
  assign pcs_rx_cg_o = pcs_rx_reg;
  assign serdes_loopback_o = serdes_lb_reg;
endmodule : pem_loopback_sel

//--- tb/pem_core_model.sv
`timescale 1ns/1ps
`include "pem_cfg.svh"

module pem_core_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pem_pkg::pem_req_s req_i,
  output pem_pkg::pem_word_t words_o [`PEM_CORE_WORDS]
);
  import pem_pkg::*;
  // Known pattern after reset so the bench can predict forwarded reads
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < `PEM_CORE_WORDS; i++) begin
      if (rst_i) begin
        words_o[i] <= pem_word_t'(16'h1111 * i);
      end else if (req_i.wr && req_i.addr == pem_addr_t'(i)) begin
        words_o[i] <= req_i.wdata;
      end
    end
  end
endmodule : pem_core_model

//--- tb/pcs_extended_mgmt_registers_test.sv
`timescale 1ns/1ps
`include "pem_cfg.svh"

module pcs_extended_mgmt_registers_test;
  import pem_pkg::*;
  logic mclk_i = 0;
  logic rst_i = 1;
  pem_req_s req = '0;
  pem_word_t rdata;
  logic an_done = 0;
  logic strap = 1;
  pem_word_t core_w [`PEM_CORE_WORDS];
  pem_req_s core_req;
  pem_cg_t tx_cg = '0, rx_cg = '0, stx, prx, tx_d, rx_d;
  logic lb_sel, lb_en, irq, evt_irq;
  logic cg_on = 0, cg_int = 0, rd_d = 0;
  pem_word_t exp_q[$];
  pem_word_t rv;
  int err_total = 0, num_checks = 0;
  integer seed = 83463;

  pem_regs DUT (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
    .an_complete_i(an_done), .loopback_position_default_i(strap), .core_rdata_i(core_w),
    .core_req_o(core_req), .tx_cg_i(tx_cg), .serdes_rx_cg_i(rx_cg), .serdes_tx_cg_o(stx),
    .pcs_rx_cg_o(prx), .serdes_loopback_o(lb_sel), .loopback_enable_o(lb_en),
    .autoneg_done_irq_out_o(irq), .evt_irq_o(evt_irq));
  pem_core_model core (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(core_req), .words_o(core_w));

  task automatic chk(input string name, input pem_word_t exp, input pem_word_t got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Read expectations are queued here and compared by the monitor
  task automatic acc(input logic w, input pem_addr_t a, input pem_word_t d, input pem_word_t e);
    @(posedge mclk_i);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    if (!w) exp_q.push_back(e);
  endtask : acc

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      req <= '0;
    end
    #1;
  endtask : idle

  task automatic pulse();
    @(posedge mclk_i);
    an_done <= 1;
    @(posedge mclk_i);
    an_done <= 0;
    #1;
  endtask : pulse

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    if (rd_d) begin
      if (exp_q.size() == 0) chk("rdata queue", 16'h1, 16'h0);
      else chk("rdata", exp_q.pop_front(), rdata);
    end else if (!rst_i) begin
      chk("rdata idle", '0, rdata);
    end
    if (cg_on) begin
      chk("serdes tx", 16'(tx_d), 16'(stx));
      chk("pcs rx", 16'(cg_int ? tx_d : rx_d), 16'(prx));
    end
    rd_d <= req.rd;
    tx_d <= tx_cg;
    rx_d <= rx_cg;
    tx_cg <= pem_cg_t'($random(seed));
    rx_cg <= pem_cg_t'($random(seed));
  end

  initial begin
    #50000;
    err_total++;
    $display("test watchdog expired");
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 0;
    acc(0, 5'h0f, '0, 16'h8000);
    acc(1, 5'h0f, 16'h7fff, '0);
    acc(0, 5'h0f, '0, 16'h8000);
    acc(0, 5'h10, '0, 16'h0001);
    acc(0, 5'h11, '0, 16'h0001);
    acc(1, 5'h10, 16'hffff, '0);
    acc(0, 5'h10, '0, 16'h0001);
    idle(2);
    chk("an irq", '0, 16'(irq));
    $display("test reset finished");
    pulse();
    chk("an irq", 16'h1, 16'(irq));
    acc(0, 5'h10, '0, 16'h0003);
    acc(1, 5'h10, 16'h0003, '0);
    acc(0, 5'h10, '0, 16'h0003);
    acc(1, 5'h10, 16'h0001, '0);
    acc(0, 5'h10, '0, 16'h0001);
    idle(2);
    chk("an irq", '0, 16'(irq));
    pulse();
    acc(1, 5'h10, 16'h0002, '0);
    acc(0, 5'h10, '0, 16'h0000);
    idle(1);
    pulse();
    chk("an irq", '0, 16'(irq));
    acc(1, 5'h10, 16'h0001, '0);
    idle(1);
    $display("test autoneg finished");
    acc(1, 5'h11, 16'h0000, '0);
    acc(1, 5'h00, 16'h4000, '0);
    acc(0, 5'h00, '0, 16'h4000);
    idle(3);
    chk("lb enable", 16'h1, 16'(lb_en));
    chk("lb serdes", '0, 16'(lb_sel));
    cg_int = 1;
    cg_on = 1;
    idle(8);
    cg_on = 0;
    acc(1, 5'h11, 16'hffff, '0);
    acc(0, 5'h11, '0, 16'h0001);
    idle(3);
    chk("lb serdes", 16'h1, 16'(lb_sel));
    cg_int = 0;
    cg_on = 1;
    idle(8);
    cg_on = 0;
    acc(1, 5'h00, 16'h0000, '0);
    idle(3);
    chk("lb serdes", '0, 16'(lb_sel));
    chk("lb enable", '0, 16'(lb_en));
    cg_on = 1;
    idle(4);
    cg_on = 0;
    $display("test loopback finished");
    acc(1, 5'h13, 16'h0003, '0);
    acc(1, 5'h14, 16'h0001, '0);
    // Unmapped reads also raise the unmapped-access event
    for (int i = 0; i < 32; i++) begin
      if (i < 15 || i > 20) acc(0, 5'(i), '0, i < 9 ? pem_word_t'(16'h1111 * i) : '0);
    end
    idle(2);
    chk("evt irq masked", '0, 16'(evt_irq));
    acc(0, 5'h12, '0, 16'h0002);
    acc(1, 5'h14, 16'h0003, '0);
    idle(2);
    chk("evt irq", 16'h1, 16'(evt_irq));
    acc(1, 5'h13, 16'h0002, '0);
    idle(2);
    chk("evt irq cleared", '0, 16'(evt_irq));
    acc(0, 5'h14, '0, 16'h0003);
    acc(0, 5'h13, '0, 16'h0000);
    rv = pem_word_t'($random(seed));
    acc(1, 5'h05, rv, '0);
    idle(1);
    acc(0, 5'h05, '0, rv);
    $display("test decode finished");
    idle(3);
    chk("rdata queue left", '0, 16'(exp_q.size()));
    print_verdict();
  end
endmodule : pcs_extended_mgmt_registers_test
